/* File: verilog/blc_pkg.sv */
// Purpose: Constants, register map and carrier types for the bipolar line codec block.
// Assumes: APB register access, one line bit per strobe on each direction.
// Notes: Printed offsets are register indexes; the byte address is four times the index.
package blc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_TX_CTRL = 8'h8c;
  localparam logic [7:0] IDX_LINE_CFG = 8'h8e;
  localparam logic [7:0] IDX_RX_CTRL = 8'h90;
  localparam logic [7:0] IDX_RX_STAT = 8'h94;
  localparam logic [7:0] IDX_RX_LATCH = 8'h96;
  localparam logic [7:0] IDX_RX_IRQ_EN = 8'h98;
  localparam logic [7:0] IDX_VIOL_CNT = 8'h9c;
  localparam logic [7:0] IDX_ZERO_CNT = 8'h9e;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int TX_DELAY = 4;
  localparam logic [2:0] B3ZS_RUN = 3'h3;
  localparam logic [2:0] HDB3_RUN = 3'h4;
  localparam logic [2:0] B3ZS_SIG_ZEROS = 3'h1;
  localparam logic [2:0] HDB3_SIG_ZEROS = 3'h2;
  localparam int LAT_SUBST = 5;
  localparam int LAT_ZERO_EVT = 4;
  localparam int LAT_ZERO_CNT = 3;
  localparam int LAT_VIOL_EVT = 2;
  localparam int LAT_VIOL_CNT = 1;
  localparam int LAT_LOSS = 0;

  typedef struct packed {
    logic pos;
    logic neg;
  } blc_bipolar_t;

  typedef struct packed {
    logic tx_subst_disable;
    logic tx_long_zero_insert_en;
    logic tx_violation_insert_en;
    logic tx_single_error_trigger;
    logic error_trigger_source_sel;
  } blc_tx_ctrl_t;

  typedef struct packed {
    logic e3_coding_violation_count_en;
    logic rx_errdet_signature_format;
    logic rx_decode_signature_format;
    logic rx_subst_decode_disable;
  } blc_rx_ctrl_t;

  typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_BAL, SYM_VIOL} blc_sym_t;
endpackage

/* File: verilog/blc_ctrl.sv */
`timescale 1ns/1ps
// Purpose: Bipolar zero-substitution line encoder, decoder, error insertion and status.
// Assumes: Line strobes and pins are synchronous to MCLK_IN; one bit per strobe.
// Notes: Transmit and receive paths each add four bit slots of latency.
module blc_ctrl (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [blc_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic TX_BIT_EN_IN,
  input wire logic TX_DATA_IN,
  input wire logic EXT_ERROR_STROBE_IN,
  output blc_pkg::blc_bipolar_t TX_LINE_OUT,
  output logic TX_LINE_VALID_OUT,
  input wire logic RX_BIT_EN_IN,
  input wire blc_pkg::blc_bipolar_t RX_LINE_IN,
  input wire logic LOSS_DETECT_IN,
  input wire logic PERF_SNAPSHOT_UPDATE_IN,
  input wire logic PORT_IRQ_EN_IN,
  output logic RX_DATA_OUT,
  output logic RX_DATA_VALID_OUT,
  output logic IRQ_OUT
);
  import blc_pkg::*;

  function automatic logic par_after(input logic p, input blc_sym_t s);
    return (s == SYM_VIOL) ? 1'b0 : (p ^ (s != SYM_ZERO));
  endfunction

  // A signature passes when formats are off, it is the first one, or polarity alternates.
  function automatic logic sig_ok(input logic fmt, input logic first, input logic pol,
                                  input logic prev);
    return first | ~fmt | (pol != prev);
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic e);
    return (e && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  blc_tx_ctrl_t tx_ctrl_q;
  blc_rx_ctrl_t rx_ctrl_q;
  logic hdb3_q;
  logic [5:0] irq_en_q;
  logic [5:0] lat_q;
  logic [15:0] viol_run_q;
  logic [15:0] zero_run_cnt_q;
  logic [15:0] viol_snap_q;
  logic [15:0] zero_snap_q;
  logic viol_nz_prev_q;
  logic zero_nz_prev_q;
  logic loss_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Register bus decode.
  logic [7:0] idx;
  logic addr_ok;
  logic apb_setup;
  logic apb_done;
  logic wr_en;
  logic [15:0] rd_val;
  logic rd_hit;
  logic [15:0] wdat;

  assign idx = PADDR_IN[9:2];
  assign addr_ok = (PADDR_IN[ADDR_W-1:10] == '0) && (PADDR_IN[1:0] == 2'h0);
  assign apb_setup = PSEL_IN & ~PENABLE_IN;
  assign apb_done = PSEL_IN & PENABLE_IN & pready_q;
  assign wr_en = apb_done & PWRITE_IN & addr_ok;
  assign wdat = PWDATA_IN[15:0];

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    case (idx)
      IDX_TX_CTRL: rd_val = {11'h000, tx_ctrl_q};
      IDX_LINE_CFG: rd_val = {15'h0000, hdb3_q};
      IDX_RX_CTRL: rd_val = {12'h000, rx_ctrl_q};
      IDX_RX_STAT: rd_val = {12'h000, |zero_snap_q, 1'b0, |viol_snap_q, loss_q};
      IDX_RX_LATCH: rd_val = {10'h000, lat_q};
      IDX_RX_IRQ_EN: rd_val = {10'h000, irq_en_q};
      IDX_VIOL_CNT: rd_val = viol_snap_q;
      IDX_ZERO_CNT: rd_val = zero_snap_q;
      default: rd_hit = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_hit = 1'b0;
    end
  end

  // The access phase always completes in its first cycle; pready rises after setup.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~rd_hit;
      if (apb_setup) begin
        prdata_q <= (PWRITE_IN || !rd_hit) ? 32'h0000_0000 : {16'h0000, rd_val};
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_ctrl_q <= blc_tx_ctrl_t'(CTRL_RESET[4:0]);
      rx_ctrl_q <= blc_rx_ctrl_t'(CTRL_RESET[3:0]);
      hdb3_q <= CTRL_RESET[0];
      irq_en_q <= CTRL_RESET[5:0];
    end else if (wr_en) begin
      case (idx)
        IDX_TX_CTRL: tx_ctrl_q <= blc_tx_ctrl_t'(wdat[4:0]);
        IDX_LINE_CFG: hdb3_q <= wdat[0];
        IDX_RX_CTRL: rx_ctrl_q <= blc_rx_ctrl_t'(wdat[3:0]);
        IDX_RX_IRQ_EN: irq_en_q <= wdat[5:0];
        default: ;
      endcase
    end
  end

  // Error trigger: the selected source is edge-detected after the mux, so a
  // source switch to an input that is high while the other is low can give one extra error.
  logic trig_sel;
  logic trig_q;
  logic err_pend_q;
  assign trig_sel = tx_ctrl_q.error_trigger_source_sel ? EXT_ERROR_STROBE_IN
                                                       : tx_ctrl_q.tx_single_error_trigger;

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_sel;
    end
  end

  // The pending flag is sticky, so repeated rises before an opportunity merge.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      err_pend_q <= 1'b0;
    end else if (trig_sel && !trig_q) begin
      err_pend_q <= 1'b1;
    end else if (TX_BIT_EN_IN) begin
      err_pend_q <= 1'b0;
    end
  end

  // Transmit encoder: four-slot symbol buffer, substitution decided on entry.
  blc_sym_t tx_buf_q [TX_DELAY];
  blc_sym_t tx_nb [TX_DELAY];
  logic tx_par_q;
  logic tx_p0;
  logic tx_last_pos_q;
  logic [2:0] tx_zero_force_q;
  blc_bipolar_t tx_line_q;
  logic tx_valid_q;

  always_comb begin
    tx_p0 = par_after(tx_par_q, tx_buf_q[0]);
    for (int i = 0; i < TX_DELAY - 1; i++) begin
      tx_nb[i] = tx_buf_q[i+1];
    end
    tx_nb[TX_DELAY-1] = TX_DATA_IN ? SYM_ONE : SYM_ZERO;
    if (!tx_ctrl_q.tx_subst_disable) begin
      if (hdb3_q && tx_nb[0] == SYM_ZERO && tx_nb[1] == SYM_ZERO && tx_nb[2] == SYM_ZERO
          && tx_nb[3] == SYM_ZERO) begin
        tx_nb[0] = tx_p0 ? SYM_ZERO : SYM_BAL;
        tx_nb[3] = SYM_VIOL;
      end else if (!hdb3_q && tx_nb[1] == SYM_ZERO && tx_nb[2] == SYM_ZERO
                   && tx_nb[3] == SYM_ZERO) begin
        tx_nb[1] = par_after(tx_p0, tx_nb[0]) ? SYM_ZERO : SYM_BAL;
        tx_nb[3] = SYM_VIOL;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < TX_DELAY; i++) begin
        tx_buf_q[i] <= SYM_ZERO;
      end
      tx_par_q <= 1'b0;
    end else if (TX_BIT_EN_IN) begin
      tx_buf_q <= tx_nb;
      tx_par_q <= tx_p0;
    end
  end

  // Line driver: forced zeros first, then an inserted violation, then the symbol.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_line_q <= '0;
      tx_last_pos_q <= 1'b0;
      tx_zero_force_q <= 3'h0;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= TX_BIT_EN_IN;
      if (TX_BIT_EN_IN) begin
        if (tx_zero_force_q != 3'h0) begin
          tx_line_q <= '0;
          tx_zero_force_q <= tx_zero_force_q - 3'h1;
        end else if (err_pend_q && tx_ctrl_q.tx_violation_insert_en) begin
          tx_line_q <= '{pos: tx_last_pos_q, neg: ~tx_last_pos_q};
        end else begin
          case (tx_buf_q[0])
            SYM_ONE, SYM_BAL: begin
              tx_line_q <= '{pos: ~tx_last_pos_q, neg: tx_last_pos_q};
              tx_last_pos_q <= ~tx_last_pos_q;
            end
            SYM_VIOL: tx_line_q <= '{pos: tx_last_pos_q, neg: ~tx_last_pos_q};
            default: tx_line_q <= '0;
          endcase
        end
        if (err_pend_q && tx_ctrl_q.tx_long_zero_insert_en) begin
          tx_zero_force_q <= hdb3_q ? HDB3_RUN : B3ZS_RUN;
        end
      end
    end
  end

  // Receive side: violation and signature detection on the raw line.
  logic rx_pulse;
  logic rx_pol;
  logic rx_viol;
  logic rx_sig_base;
  logic rx_det_sig;
  logic rx_dec_sig;
  logic rx_bpv;
  logic rx_cv;
  logic rx_err_evt;
  logic rx_zero_evt;
  logic [2:0] rx_zrun_q;
  logic rx_seen_q;
  logic rx_last_pos_q;
  logic rx_prev_viol_pos_q;
  logic rx_seen_viol_q;
  logic det_first_q;
  logic det_prev_q;
  logic dec_first_q;
  logic dec_prev_q;
  logic [TX_DELAY-1:0] rx_buf_q;
  logic [TX_DELAY-1:0] rx_nb;
  logic rx_data_q;
  logic rx_valid_q;

  assign rx_pulse = RX_LINE_IN.pos ^ RX_LINE_IN.neg;
  assign rx_pol = RX_LINE_IN.pos;
  assign rx_viol = rx_pulse & rx_seen_q & (rx_pol == rx_last_pos_q);
  assign rx_sig_base = rx_viol & (rx_zrun_q >= (hdb3_q ? HDB3_SIG_ZEROS : B3ZS_SIG_ZEROS));
  assign rx_det_sig = rx_sig_base & sig_ok(rx_ctrl_q.rx_errdet_signature_format,
                                           det_first_q, rx_pol, det_prev_q);
  assign rx_dec_sig = rx_sig_base & sig_ok(rx_ctrl_q.rx_decode_signature_format,
                                           dec_first_q, rx_pol, dec_prev_q);
  assign rx_bpv = rx_viol & ~(rx_det_sig & ~rx_ctrl_q.rx_subst_decode_disable);
  assign rx_cv = rx_viol & rx_seen_viol_q & (rx_pol == rx_prev_viol_pos_q);
  assign rx_err_evt = RX_BIT_EN_IN & ((hdb3_q && rx_ctrl_q.e3_coding_violation_count_en)
                                      ? rx_cv : rx_bpv);
  assign rx_zero_evt = RX_BIT_EN_IN & ~rx_pulse
                       & (rx_zrun_q == (hdb3_q ? HDB3_RUN : B3ZS_RUN) - 3'h1);

  always_comb begin
    rx_nb = {rx_pulse, rx_buf_q[TX_DELAY-1:1]};
    if (!rx_ctrl_q.rx_subst_decode_disable && rx_dec_sig) begin
      rx_nb[TX_DELAY-1] = 1'b0;
      if (hdb3_q) begin
        rx_nb[0] = 1'b0;
      end else begin
        rx_nb[1] = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_buf_q <= '0;
      rx_data_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_zrun_q <= 3'h0;
      rx_seen_q <= 1'b0;
      rx_last_pos_q <= 1'b0;
    end else begin
      rx_valid_q <= RX_BIT_EN_IN;
      if (RX_BIT_EN_IN) begin
        rx_buf_q <= rx_nb;
        rx_data_q <= rx_buf_q[0];
        if (rx_pulse) begin
          rx_zrun_q <= 3'h0;
          rx_seen_q <= 1'b1;
          rx_last_pos_q <= rx_pol;
        end else if (rx_zrun_q != 3'h7) begin
          rx_zrun_q <= rx_zrun_q + 3'h1;
        end
      end
    end
  end

  // Signature history: the first signature after reset ignores the format bits.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      det_first_q <= 1'b1;
      det_prev_q <= 1'b0;
      dec_first_q <= 1'b1;
      dec_prev_q <= 1'b0;
      rx_seen_viol_q <= 1'b0;
      rx_prev_viol_pos_q <= 1'b0;
    end else if (RX_BIT_EN_IN) begin
      if (rx_det_sig) begin
        det_first_q <= 1'b0;
        det_prev_q <= rx_pol;
      end
      if (rx_dec_sig) begin
        dec_first_q <= 1'b0;
        dec_prev_q <= rx_pol;
      end
      if (rx_viol) begin
        rx_seen_viol_q <= 1'b1;
        rx_prev_viol_pos_q <= rx_pol;
      end
    end
  end

  // Running counters restart on each snapshot, which also loads the readable copies.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      viol_run_q <= 16'h0000;
      zero_run_cnt_q <= 16'h0000;
      viol_snap_q <= 16'h0000;
      zero_snap_q <= 16'h0000;
    end else if (PERF_SNAPSHOT_UPDATE_IN) begin
      viol_snap_q <= viol_run_q;
      zero_snap_q <= zero_run_cnt_q;
      viol_run_q <= {15'h0000, rx_err_evt};
      zero_run_cnt_q <= {15'h0000, rx_zero_evt};
    end else begin
      viol_run_q <= sat_inc(viol_run_q, rx_err_evt);
      zero_run_cnt_q <= sat_inc(zero_run_cnt_q, rx_zero_evt);
    end
  end

  // Status, latched flags and interrupt.
  logic loss_d;
  logic [5:0] lat_set;
  logic [5:0] lat_clr;
  assign loss_d = LOSS_DETECT_IN & ~rx_ctrl_q.rx_subst_decode_disable;
  assign lat_clr = (wr_en && idx == IDX_RX_LATCH) ? wdat[5:0] : 6'h00;

  always_comb begin
    lat_set = 6'h00;
    lat_set[LAT_SUBST] = RX_BIT_EN_IN & rx_det_sig;
    lat_set[LAT_ZERO_EVT] = rx_zero_evt;
    lat_set[LAT_ZERO_CNT] = (|zero_snap_q) & ~zero_nz_prev_q;
    lat_set[LAT_VIOL_EVT] = rx_err_evt;
    lat_set[LAT_VIOL_CNT] = (|viol_snap_q) & ~viol_nz_prev_q;
    lat_set[LAT_LOSS] = loss_d ^ loss_q;
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      loss_q <= 1'b0;
      viol_nz_prev_q <= 1'b0;
      zero_nz_prev_q <= 1'b0;
      lat_q <= 6'h00;
      IRQ_OUT <= 1'b0;
    end else begin
      loss_q <= loss_d;
      viol_nz_prev_q <= |viol_snap_q;
      zero_nz_prev_q <= |zero_snap_q;
      lat_q <= (lat_q & ~lat_clr) | lat_set;
      IRQ_OUT <= PORT_IRQ_EN_IN & |(lat_q & irq_en_q);
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign TX_LINE_OUT = tx_line_q;
  assign TX_LINE_VALID_OUT = tx_valid_q;
  assign RX_DATA_OUT = rx_data_q;
  assign RX_DATA_VALID_OUT = rx_valid_q;
endmodule

/* File: sim/blc_ctrl_monitor.sv */
`timescale 1ns/1ps
// Purpose: Concurrent checks on the register bus, line strobes and interrupt of the codec.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the codec block.
module blc_ctrl_monitor
  import blc_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [blc_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic TX_BIT_EN_IN,
  input wire blc_pkg::blc_bipolar_t TX_LINE_OUT,
  input wire logic TX_LINE_VALID_OUT,
  input wire logic RX_BIT_EN_IN,
  input wire logic RX_DATA_VALID_OUT,
  input wire logic PORT_IRQ_EN_IN,
  input wire logic IRQ_OUT
);
  default clocking d_clk @(posedge MCLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_answer;
    PREADY_OUT && (PRDATA_OUT[31:16] == 16'h0000);
  endsequence
  property p_apb_answer;
    s_setup |=> s_answer ##1 !PREADY_OUT;
  endproperty
  property p_refuse;
    PSEL_IN && !PENABLE_IN && (PADDR_IN[1:0] != 2'h0 || PADDR_IN[11:10] != 2'h0)
      |=> PREADY_OUT && PSLVERR_OUT;
  endproperty
  property p_err_ready;
    PSLVERR_OUT |-> PREADY_OUT;
  endproperty
  property p_tx_hold;
    !TX_BIT_EN_IN |=> $stable(TX_LINE_OUT) && !TX_LINE_VALID_OUT;
  endproperty
  property p_tx_strobe;
    TX_BIT_EN_IN |=> TX_LINE_VALID_OUT && !(TX_LINE_OUT.pos && TX_LINE_OUT.neg);
  endproperty
  property p_rx_strobe;
    RX_BIT_EN_IN |=> RX_DATA_VALID_OUT;
  endproperty
  property p_rx_quiet;
    !RX_BIT_EN_IN |=> !RX_DATA_VALID_OUT;
  endproperty
  property p_irq_port;
    !PORT_IRQ_EN_IN |=> !IRQ_OUT;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus access not answered in one cycle");
  a_refuse: assert property (p_refuse) else $error("bad address not refused");
  a_err_ready: assert property (p_err_ready) else $error("error response without ready");
  a_tx_hold: assert property (p_tx_hold) else $error("line output moved without strobe");
  a_tx_strobe: assert property (p_tx_strobe) else $error("bad line symbol after strobe");
  a_rx_strobe: assert property (p_rx_strobe) else $error("no decoded bit after slot");
  a_rx_quiet: assert property (p_rx_quiet) else $error("decoded bit without slot");
  a_irq_port: assert property (p_irq_port) else $error("interrupt with port disabled");
endmodule
bind blc_ctrl blc_ctrl_monitor i_mon (.MCLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN,
  .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .TX_BIT_EN_IN, .TX_LINE_OUT, .TX_LINE_VALID_OUT,
  .RX_BIT_EN_IN, .RX_DATA_VALID_OUT, .PORT_IRQ_EN_IN, .IRQ_OUT);

/* File: sim/blc_line_model.sv */
`timescale 1ns/1ps
// Purpose: Line interface model that loops each transmitted symbol back as a receive slot.
// Assumes: Transmit symbols are qualified by their valid pulse.
// Notes: Between slots the line pair toggles so that stale symbols are never seen as fresh.
module blc_line_model
  import blc_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire blc_pkg::blc_bipolar_t line_in,
  input wire logic line_valid_in,
  output logic strobe_out,
  output blc_pkg::blc_bipolar_t line_out
);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_out <= 1'b0;
      line_out <= '0;
    end else if (line_valid_in) begin
      strobe_out <= 1'b1;
      line_out <= line_in;
    end else begin
      strobe_out <= 1'b0;
      line_out <= ~line_out;
    end
  end
endmodule

/* File: sim/blc_ctrl_tb.sv */
`timescale 1ns/1ps
// Purpose: Self-checking bench for the codec with its line looped back through a model.
// Assumes: Bit i of a burst shows on the line four slots later and decoded eight slots later.
// Notes: Count registers are zeroed by two snapshots before each error case.
module blc_ctrl_tb;
  import blc_pkg::*;
  localparam logic [11:0] A_TX = {2'h0, IDX_TX_CTRL, 2'h0};
  localparam logic [11:0] A_CFG = {2'h0, IDX_LINE_CFG, 2'h0};
  localparam logic [11:0] A_RXC = {2'h0, IDX_RX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, IDX_RX_STAT, 2'h0};
  localparam logic [11:0] A_LAT = {2'h0, IDX_RX_LATCH, 2'h0};
  localparam logic [11:0] A_IEN = {2'h0, IDX_RX_IRQ_EN, 2'h0};
  localparam logic [11:0] A_VCNT = {2'h0, IDX_VIOL_CNT, 2'h0};
  localparam logic [11:0] A_ZCNT = {2'h0, IDX_ZERO_CNT, 2'h0};
  localparam logic [13:0] PAT = 14'h2181;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tx_en = 1'b0;
  logic tx_d = 1'b0;
  logic ext_stb = 1'b0;
  logic loss = 1'b0;
  logic perf = 1'b0;
  logic port_en = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_vld, rx_en, rx_d, rx_vld, irq;
  blc_bipolar_t tx_line, rx_line;
  blc_bipolar_t line_q[$];
  logic rx_q[$];
  int n_sent = 0;
  int num_errors = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  blc_ctrl i_dut (.MCLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TX_BIT_EN_IN(tx_en), .TX_DATA_IN(tx_d),
    .EXT_ERROR_STROBE_IN(ext_stb), .TX_LINE_OUT(tx_line), .TX_LINE_VALID_OUT(tx_vld),
    .RX_BIT_EN_IN(rx_en), .RX_LINE_IN(rx_line), .LOSS_DETECT_IN(loss),
    .PERF_SNAPSHOT_UPDATE_IN(perf), .PORT_IRQ_EN_IN(port_en), .RX_DATA_OUT(rx_d),
    .RX_DATA_VALID_OUT(rx_vld), .IRQ_OUT(irq));
  blc_line_model i_line (.clk_in(clk), .arst_n_in(arst_n), .line_in(tx_line),
    .line_valid_in(tx_vld), .strobe_out(rx_en), .line_out(rx_line));
  always @(posedge clk) begin
    if (tx_vld === 1'b1) line_q.push_back(tx_line);
    if (rx_vld === 1'b1) rx_q.push_back(rx_d);
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, rd & m, e);
  endtask
  task automatic send(input logic b);
    @(posedge clk);
    tx_en <= 1'b1;
    tx_d <= b;
    n_sent++;
    @(posedge clk);
    tx_en <= 1'b0;
  endtask
  // Ones sent back to back push every earlier bit out of both pipelines.
  task automatic flush(input int n);
    repeat (n) begin
      @(posedge clk);
      tx_en <= 1'b1;
      tx_d <= 1'b1;
      n_sent++;
    end
    @(posedge clk);
    tx_en <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic snap();
    @(posedge clk);
    perf <= 1'b1;
    @(posedge clk);
    perf <= 1'b0;
  endtask
  task automatic regs();
    logic [31:0] rd;
    logic er;
    rd_chk("tx ctrl reset", A_TX, 32'hffffffff, 32'h0);
    rd_chk("line cfg reset", A_CFG, 32'hffffffff, 32'h0);
    rd_chk("rx ctrl reset", A_RXC, 32'hffffffff, 32'h0);
    rd_chk("irq en reset", A_IEN, 32'hffffffff, 32'h0);
    wr(A_RXC, 32'hffff);
    rd_chk("rx ctrl bits", A_RXC, 32'hffffffff, 32'hf);
    wr(A_RXC, 32'h0);
    wr(A_VCNT, 32'h1234);
    rd_chk("count read only", A_VCNT, 32'hffffffff, 32'h0);
    apb(1'b0, 12'h234, 32'h0, rd, er);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h231, 32'h1, rd, er);
    chk("misaligned err", er, 32'h1);
    apb(1'b0, 12'hc30, 32'h0, rd, er);
    chk("high address err", er, 32'h1);
  endtask
  task automatic dat_case(input logic [31:0] cfg, input logic [31:0] sd, input logic [31:0] rxd);
    int base;
    int np;
    wr(A_CFG, cfg);
    wr(A_TX, sd << 4);
    wr(A_RXC, rxd);
    wr(A_LAT, 32'h3f);
    base = n_sent;
    for (int i = 0; i < 14; i++) send(PAT[i]);
    flush(8);
    np = 0;
    for (int i = 1; i < 7; i++) np += line_q[base + 4 + i].pos | line_q[base + 4 + i].neg;
    chk("zero run pulses", np != 0, sd == 0);
    for (int i = 0; i < 14; i++) chk("decoded bit", rx_q[base + 8 + i], PAT[i]);
    rd_chk("code seen", A_LAT, 32'h20, (sd == 0) ? 32'h20 : 32'h0);
  endtask
  task automatic err_case(input logic [31:0] base, input logic ext, input logic ev,
                          input logic ez);
    snap();
    snap();
    wr(A_LAT, 32'h3f);
    wr(A_TX, base);
    if (ext) begin
      @(posedge clk);
      ext_stb <= 1'b1;
      @(posedge clk);
      ext_stb <= 1'b0;
    end else begin
      wr(A_TX, base | 32'h2);
      wr(A_TX, base);
      wr(A_TX, base | 32'h2);
    end
    flush(16);
    snap();
    rd_chk("viol count", A_VCNT, 32'hffffffff, {31'h0, ev});
    rd_chk("zero count", A_ZCNT, 32'hffffffff, {31'h0, ez});
    rd_chk("status", A_STAT, 32'hf, {28'h0, ez, 1'b0, ev, 1'b0});
    rd_chk("latched", A_LAT, 32'h3f, {26'h0, 1'b0, ez, ez, ev, ev, 1'b0});
    wr(A_TX, base & 32'hfffffffd);
    wr(A_TX, 32'h0);
  endtask
  task automatic loss_case();
    int n;
    wr(A_IEN, 32'h1);
    wr(A_LAT, 32'h3f);
    loss <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("loss status", A_STAT, 32'h1, 32'h1);
    rd_chk("loss change", A_LAT, 32'h1, 32'h1);
    @(posedge clk);
    chk("irq port off", irq, 32'h0);
    port_en <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 8);
    chk("irq raised", irq, 32'h1);
    wr(A_LAT, 32'h3f);
    rd_chk("flag cleared", A_LAT, 32'h1, 32'h0);
    // The last loss change lands on the clearing edge, so the flag must survive the clear.
    fork
      wr(A_LAT, 32'h3f);
      begin
        @(posedge clk);
        loss <= 1'b0;
        @(posedge clk);
        loss <= 1'b1;
      end
    join
    rd_chk("set beats clear", A_LAT, 32'h1, 32'h1);
    wr(A_RXC, 32'h1);
    repeat (4) @(posedge clk);
    rd_chk("loss forced clear", A_STAT, 32'h1, 32'h0);
    rd_chk("loss change", A_LAT, 32'h1, 32'h1);
    loss <= 1'b0;
    wr(A_LAT, 32'h3f);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b0 && n < 8);
    chk("irq dropped", irq, 32'h0);
    wr(A_RXC, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    regs();
    dat_case(32'h0, 32'h1, 32'h1);
    dat_case(32'h0, 32'h0, 32'h0);
    dat_case(32'h1, 32'h0, 32'h0);
    wr(A_CFG, 32'h0);
    err_case(32'h04, 1'b0, 1'b1, 1'b0);
    err_case(32'h00, 1'b0, 1'b0, 1'b0);
    err_case(32'h08, 1'b0, 1'b0, 1'b1);
    err_case(32'h0c, 1'b0, 1'b1, 1'b1);
    err_case(32'h05, 1'b1, 1'b1, 1'b0);
    // Fifteen pulses part two inserted violations, so their polarities differ; one more matches them.
    wr(A_CFG, 32'h1);
    wr(A_RXC, 32'hc);
    err_case(32'h04, 1'b0, 1'b0, 1'b0);
    send(1'b1);
    err_case(32'h04, 1'b0, 1'b1, 1'b0);
    loss_case();
    close_out();
  end
endmodule
